// ===== rtl/paa_consts.svh
// Offsets, codes, selectors and field layouts of the analog access block.
`ifndef PAA_CONSTS_SVH
`define PAA_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PAA_OFS_ARG_LO    8'h84
`define PAA_OFS_ARG_HI    8'h85
`define PAA_OFS_RES_LO    8'h88
`define PAA_OFS_RES_HI    8'h89

// ----------------------------------------------------------------------
// Attribute codes, load arguments and the fail result
// ----------------------------------------------------------------------
`define PAA_CMD_RD        16'h002C
`define PAA_CMD_WR        16'h006C
`define PAA_CMD_LOAD      16'h00EC
`define PAA_CMD_IDLE_ST   16'h4027
`define PAA_LOAD_CTLE     16'h0015
`define PAA_LOAD_DFE      16'h0012
`define PAA_RES_FAIL      16'h0000

// ----------------------------------------------------------------------
// Parameter selectors
// ----------------------------------------------------------------------
`define PAA_SEL_CTLE      16'h0900
`define PAA_SEL_DFE       16'h0D00
`define PAA_RANGE_MASK    16'hFFF0
`define PAA_RANGE_LAST    4'hA
`define PAA_CTLE_VALID    11'h7B3
`define PAA_DFE_VALID     11'h79F
`define PAA_SEL_B0X       16'h200B
`define PAA_SEL_TP_A      16'h2001
`define PAA_SEL_TP_B      16'h2002
`define PAA_SEL_FIX_CTLE  16'h0108
`define PAA_SEL_FIX_DFE   16'h0109
`define PAA_SEL_IDLE_CFG  16'h011C
`define PAA_SEL_EFFORT    16'h0118
`define PAA_SEL_EYE       16'h1700
`define PAA_EYE_MASK      16'hFFF8
`define PAA_EYE_LAST      3'h5

// ----------------------------------------------------------------------
// Storage indices, field masks and values
// ----------------------------------------------------------------------
`define PAA_NPARAM        25
`define PAA_IDX_DFE       5'h0B
`define PAA_IDX_B0X       5'h16
`define PAA_IDX_TP_A      5'h17
`define PAA_IDX_TP_B      5'h18
`define PAA_FIX_CTLE_MASK 8'h32
`define PAA_FIX_DFE_MASK  8'h19
`define PAA_EFFORT_FULL   2'h1
`define PAA_CFG_EN        0
`define PAA_CFG_OSC       1
`define PAA_CFG_TUNE      2
`define PAA_ST_NOSIG      8'h30
`define PAA_ST_SIG        8'h20

`endif

// ===== rtl/paa_pkg.sv
// Types shared by the analog access block and its users.
package paa_pkg;

    typedef enum logic [0:0] {
        PAA_IDLE = 1'b0,
        PAA_RUN  = 1'b1
    } paa_state_t;

    // Attribute launch: code plus its strobe.
    typedef struct packed {
        logic        valid;
        logic [15:0] code;
    } paa_cmd_t;

    // Selector decode result for the parameter store.
    typedef struct packed {
        logic       ok;
        logic [4:0] idx;
    } paa_sel_t;

    // Six eye heights, index 0 is the lower even eye.
    typedef logic [5:0][15:0] paa_eye_t;

endpackage

// ===== rtl/paa_core.sv
// Attribute interpreter for receiver analog parameter access.
`timescale 1ns/1ns
`default_nettype none
`include "paa_consts.svh"

module paa_core (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata_r,
    output logic                   reg_rvalid_r,
    input  wire paa_pkg::paa_cmd_t cmd,
    output logic                   cmd_busy_r,
    output logic                   cmd_done_r,
    input  wire logic              rx_idle,
    input  wire logic              rx_pam4,
    input  wire paa_pkg::paa_eye_t eye_height,
    output logic                   load_ctle_r,
    output logic                   load_dfe_r,
    output logic      [7:0]        fix_ctle_r,
    output logic      [7:0]        fix_dfe_r,
    output logic      [15:0]       idle_cfg_r,
    output logic      [1:0]        effort_r,
    output logic                   idle_status_r
);
    import paa_pkg::*;

    localparam logic [10:0] CTLE_OK = `PAA_CTLE_VALID;
    localparam logic [10:0] DFE_OK  = `PAA_DFE_VALID;

    // ------------------------------------------------------------------
    // Selector decode
    // ------------------------------------------------------------------
    // Maps a selector onto the parameter store; holes in a range fail.
    function automatic paa_sel_t sel_decode(input logic [15:0] s);
        paa_sel_t d;
        d.ok  = 1'b0;
        d.idx = 5'h00;
        if ((s & `PAA_RANGE_MASK) == `PAA_SEL_CTLE &&
            s[3:0] <= `PAA_RANGE_LAST) begin
            d.ok  = CTLE_OK[s[3:0]];
            d.idx = {1'b0, s[3:0]};
        end else if ((s & `PAA_RANGE_MASK) == `PAA_SEL_DFE &&
                     s[3:0] <= `PAA_RANGE_LAST) begin
            d.ok  = DFE_OK[s[3:0]];
            d.idx = 5'(`PAA_IDX_DFE + {1'b0, s[3:0]});
        end else if (s == `PAA_SEL_B0X) begin
            d.ok  = 1'b1;
            d.idx = `PAA_IDX_B0X;
        end else if (s == `PAA_SEL_TP_A) begin
            d.ok  = 1'b1;
            d.idx = `PAA_IDX_TP_A;
        end else if (s == `PAA_SEL_TP_B) begin
            d.ok  = 1'b1;
            d.idx = `PAA_IDX_TP_B;
        end
        return d;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] arg_r,  arg_nxt;
    logic [7:0]  rdata_nxt;
    logic        rvalid_nxt;
    paa_state_t  state_r, state_nxt;
    logic [15:0] code_r, code_nxt;
    logic [15:0] res_r,  res_nxt;
    logic [15:0] sel_r,  sel_nxt;
    logic        armed_r, armed_nxt;
    logic        done_nxt, busy_nxt, lctle_nxt, ldfe_nxt;
    logic        wr_sel, wr_ok;
    logic [15:0] rd_val;
    paa_sel_t    rd_dec, wr_dec;
    logic [15:0] param_r [`PAA_NPARAM];
    logic [15:0] param_nxt [`PAA_NPARAM];
    logic [7:0]  fix_ctle_nxt, fix_dfe_nxt;
    logic [15:0] cfg_nxt;
    logic [1:0]  effort_nxt;
    logic [11:0] cnt_r, cnt_nxt;
    logic        osc_r, osc_nxt, flag, st_nxt;

    // ------------------------------------------------------------------
    // Argument and result byte registers
    // ------------------------------------------------------------------
    // Result bytes are read-only; unmapped reads answer zero.
    always_comb begin
        arg_nxt    = arg_r;
        rvalid_nxt = reg_rd;
        rdata_nxt  = 8'h00;
        if (reg_wr) begin
            case (reg_addr)
                `PAA_OFS_ARG_LO: arg_nxt[7:0]  = reg_wdata;
                `PAA_OFS_ARG_HI: arg_nxt[15:8] = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `PAA_OFS_ARG_LO: rdata_nxt = arg_r[7:0];
                `PAA_OFS_ARG_HI: rdata_nxt = arg_r[15:8];
                `PAA_OFS_RES_LO: rdata_nxt = res_r[7:0];
                `PAA_OFS_RES_HI: rdata_nxt = res_r[15:8];
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            arg_r        <= 16'h0000;
            reg_rdata_r  <= 8'h00;
            reg_rvalid_r <= 1'b0;
        end else begin
            arg_r        <= arg_nxt;
            reg_rdata_r  <= rdata_nxt;
            reg_rvalid_r <= rvalid_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read value and write target
    // ------------------------------------------------------------------
    // In NRZ only one eye exists, so every eye selector returns it.
    always_comb begin
        rd_dec = sel_decode(arg_r);
        wr_dec = sel_decode(sel_r);
        rd_val = 16'h0000;
        if (rd_dec.ok) begin
            rd_val = param_r[rd_dec.idx];
        end else if (arg_r == `PAA_SEL_FIX_CTLE) begin
            rd_val = {8'h00, fix_ctle_r};
        end else if (arg_r == `PAA_SEL_FIX_DFE) begin
            rd_val = {8'h00, fix_dfe_r};
        end else if (arg_r == `PAA_SEL_IDLE_CFG) begin
            rd_val = idle_cfg_r;
        end else if (arg_r == `PAA_SEL_EFFORT) begin
            rd_val = {14'h0000, effort_r};
        end else if ((arg_r & `PAA_EYE_MASK) == `PAA_SEL_EYE &&
                     arg_r[2:0] <= `PAA_EYE_LAST) begin
            rd_val = rx_pam4 ? eye_height[arg_r[2:0]]
                             : eye_height[0];
        end
        wr_ok = wr_dec.ok ||
                sel_r == `PAA_SEL_FIX_CTLE ||
                sel_r == `PAA_SEL_FIX_DFE ||
                sel_r == `PAA_SEL_IDLE_CFG ||
                sel_r == `PAA_SEL_EFFORT;
    end

    // ------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------
    // A launch is taken only when idle; the argument is sampled in the
    // execute cycle, so it must not change while busy.
    always_comb begin
        state_nxt = state_r;
        code_nxt  = code_r;
        res_nxt   = res_r;
        sel_nxt   = sel_r;
        armed_nxt = armed_r;
        done_nxt  = 1'b0;
        lctle_nxt = 1'b0;
        ldfe_nxt  = 1'b0;
        wr_sel    = 1'b0;
        case (state_r)
            PAA_IDLE: begin
                if (cmd.valid) begin
                    state_nxt = PAA_RUN;
                    code_nxt  = cmd.code;
                end
            end
            PAA_RUN: begin
                state_nxt = PAA_IDLE;
                done_nxt  = 1'b1;
                armed_nxt = 1'b0;
                res_nxt   = `PAA_RES_FAIL;
                case (code_r)
                    `PAA_CMD_RD: begin
                        sel_nxt   = arg_r;
                        armed_nxt = 1'b1;
                        res_nxt   = rd_val;
                    end
                    `PAA_CMD_WR: begin
                        if (armed_r && wr_ok) begin
                            wr_sel  = 1'b1;
                            res_nxt = `PAA_CMD_RD;
                        end
                    end
                    `PAA_CMD_LOAD: begin
                        if (arg_r == `PAA_LOAD_CTLE) begin
                            lctle_nxt = 1'b1;
                            res_nxt   = `PAA_CMD_LOAD;
                        end else if (arg_r == `PAA_LOAD_DFE) begin
                            ldfe_nxt = 1'b1;
                            res_nxt  = `PAA_CMD_LOAD;
                        end
                    end
                    `PAA_CMD_IDLE_ST: begin
                        if (arg_r == 16'h0000) begin
                            res_nxt = {8'h00, idle_status_r ?
                                `PAA_ST_NOSIG : `PAA_ST_SIG};
                        end
                    end
                    default: ;
                endcase
            end
            default: state_nxt = PAA_IDLE;
        endcase
        busy_nxt = (state_nxt == PAA_RUN);
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r     <= PAA_IDLE;
            code_r      <= 16'h0000;
            res_r       <= 16'h0000;
            sel_r       <= 16'h0000;
            armed_r     <= 1'b0;
            cmd_done_r  <= 1'b0;
            cmd_busy_r  <= 1'b0;
            load_ctle_r <= 1'b0;
            load_dfe_r  <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            code_r      <= code_nxt;
            res_r       <= res_nxt;
            sel_r       <= sel_nxt;
            armed_r     <= armed_nxt;
            cmd_done_r  <= done_nxt;
            cmd_busy_r  <= busy_nxt;
            load_ctle_r <= lctle_nxt;
            load_dfe_r  <= ldfe_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Parameter store and settings
    // ------------------------------------------------------------------
    // Fix masks keep only their defined bits; the rest read as zero.
    always_comb begin
        for (int i = 0; i < `PAA_NPARAM; i++) begin
            param_nxt[i] = param_r[i];
        end
        fix_ctle_nxt = fix_ctle_r;
        fix_dfe_nxt  = fix_dfe_r;
        cfg_nxt      = idle_cfg_r;
        effort_nxt   = effort_r;
        if (wr_sel) begin
            if (wr_dec.ok) begin
                param_nxt[wr_dec.idx] = arg_r;
            end else if (sel_r == `PAA_SEL_FIX_CTLE) begin
                fix_ctle_nxt = arg_r[7:0] & `PAA_FIX_CTLE_MASK;
            end else if (sel_r == `PAA_SEL_FIX_DFE) begin
                fix_dfe_nxt = arg_r[7:0] & `PAA_FIX_DFE_MASK;
            end else if (sel_r == `PAA_SEL_IDLE_CFG) begin
                cfg_nxt = arg_r;
            end else begin
                effort_nxt = arg_r[1:0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < `PAA_NPARAM; i++) begin
                param_r[i] <= 16'h0000;
            end
            fix_ctle_r <= 8'h00;
            fix_dfe_r  <= 8'h00;
            idle_cfg_r <= 16'h0000;
            effort_r   <= `PAA_EFFORT_FULL;
        end else begin
            for (int i = 0; i < `PAA_NPARAM; i++) begin
                param_r[i] <= param_nxt[i];
            end
            fix_ctle_r <= fix_ctle_nxt;
            fix_dfe_r  <= fix_dfe_nxt;
            idle_cfg_r <= cfg_nxt;
            effort_r   <= effort_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Idle detector filter
    // ------------------------------------------------------------------
    // One polling loop is one clock; the counter saturates rather than
    // wrapping so a long idle never looks like a fresh one.
    always_comb begin
        cnt_nxt = rx_idle ? ((cnt_r == 12'hFFF) ? cnt_r
                                                : 12'(cnt_r + 12'h001))
                          : 12'h000;
        osc_nxt = ~osc_r;
        if (idle_cfg_r[`PAA_CFG_TUNE]) begin
            flag = eye_height[0] < {4'h0, idle_cfg_r[15:4]};
        end else begin
            flag = rx_idle && cnt_r >= idle_cfg_r[15:4];
        end
        if (!idle_cfg_r[`PAA_CFG_EN]) begin
            st_nxt = rx_idle;
        end else begin
            st_nxt = flag |
                (idle_cfg_r[`PAA_CFG_OSC] & ~flag & osc_r);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r         <= 12'h000;
            osc_r         <= 1'b0;
            idle_status_r <= 1'b0;
        end else begin
            cnt_r         <= cnt_nxt;
            osc_r         <= osc_nxt;
            idle_status_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_launch;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_r == PAA_IDLE && cmd.valid) |=> cmd_busy_r ##1 cmd_done_r;
    endproperty
    a_launch: assert property (p_launch)
        else $error("Launch did not complete in two cycles.");

    property p_wr_ok;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_r == PAA_RUN && code_r == `PAA_CMD_WR && armed_r && wr_ok)
        |=> res_r == `PAA_CMD_RD;
    endproperty
    a_wr_ok: assert property (p_wr_ok)
        else $error("Successful write did not report read code.");

    property p_wr_target;
        @(posedge sys_clk) disable iff (sys_rst)
        (wr_sel && wr_dec.ok) |=> param_r[$past(wr_dec.idx)] == $past(arg_r);
    endproperty
    a_wr_target: assert property (p_wr_target)
        else $error("Write missed the last read selector.");

    property p_fix_mask;
        @(posedge sys_clk) disable iff (sys_rst)
        ((fix_ctle_r & ~`PAA_FIX_CTLE_MASK) == 8'h00) &&
        ((fix_dfe_r & ~`PAA_FIX_DFE_MASK) == 8'h00);
    endproperty
    a_fix_mask: assert property (p_fix_mask)
        else $error("Undefined fix bit set.");

    property p_load;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_r == PAA_RUN && code_r == `PAA_CMD_LOAD &&
         arg_r == `PAA_LOAD_CTLE) |=> load_ctle_r && !load_dfe_r ##1 !load_ctle_r;
    endproperty
    a_load: assert property (p_load)
        else $error("Gain load pulse wrong.");

    property p_res_hi;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == `PAA_OFS_RES_HI)
        |=> reg_rvalid_r && reg_rdata_r == $past(res_r[15:8]);
    endproperty
    a_res_hi: assert property (p_res_hi)
        else $error("Result high byte wrong.");

    property p_idle_st;
        @(posedge sys_clk) disable iff (sys_rst)
        (state_r == PAA_RUN && code_r == `PAA_CMD_IDLE_ST && arg_r == 16'h0000)
        |=> res_r == ($past(idle_status_r) ? 16'h0030 : 16'h0020);
    endproperty
    a_idle_st: assert property (p_idle_st)
        else $error("Idle status code wrong.");

    property p_unfiltered;
        @(posedge sys_clk) disable iff (sys_rst)
        !idle_cfg_r[`PAA_CFG_EN] |=> idle_status_r == $past(rx_idle);
    endproperty
    a_unfiltered: assert property (p_unfiltered)
        else $error("Status filtered while filtering is off.");

    property p_effort;
        @(posedge sys_clk) disable iff (sys_rst)
        (wr_sel && sel_r == `PAA_SEL_EFFORT) |=> effort_r == $past(arg_r[1:0]);
    endproperty
    a_effort: assert property (p_effort)
        else $error("Effort write lost.");

endmodule

`default_nettype wire

// ===== verification/paa_host.sv
// Host model that speaks the byte register bus and launches attributes.
`timescale 1ns/1ns
`default_nettype none
`include "paa_consts.svh"

module paa_host (
    input  wire logic         sys_clk,
    output logic [7:0]        reg_addr,
    output logic              reg_wr,
    output logic              reg_rd,
    output logic [7:0]        reg_wdata,
    output paa_pkg::paa_cmd_t cmd,
    input  wire logic [7:0]   reg_rdata_r,
    input  wire logic         reg_rvalid_r,
    input  wire logic         cmd_done_r
);
    import paa_pkg::*;

    // Idle bus at time zero.
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        cmd = '0;
    end

    // Released lines are inverted so nobody can lean on stale values.
    task automatic bwr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk) #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // The answer stands one cycle, so it is taken right after the edge.
    task automatic brd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk) #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = (reg_rvalid_r === 1'b1) ? reg_rdata_r : 8'hXX;
    endtask

    // One attribute: argument, launch, bounded wait for done, result.
    task automatic attr(input logic [15:0] code, input logic [15:0] arg,
                        output logic [15:0] res);
        int         n;
        logic [7:0] lo;
        logic [7:0] hi;
        bwr(`PAA_OFS_ARG_LO, arg[7:0]);
        bwr(`PAA_OFS_ARG_HI, arg[15:8]);
        @(posedge sys_clk) #1;
        cmd = {1'b1, code};
        @(posedge sys_clk) #1;
        cmd = {1'b0, ~code};
        n = 0;
        while (cmd_done_r !== 1'b1 && n < 8) begin
            @(posedge sys_clk) #1;
            n++;
        end
        brd(`PAA_OFS_RES_LO, lo);
        brd(`PAA_OFS_RES_HI, hi);
        res = (n < 8) ? {hi, lo} : 16'hXXXX;
    endtask
endmodule
`default_nettype wire

// ===== verification/test_pma_analog_param_access.sv
// Self-checking testbench of the analog access block.
`timescale 1ns/1ns
`default_nettype none

module test_pma_analog_param_access;
    import paa_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst, reg_wr, reg_rd, reg_rvalid_r, cmd_busy_r, cmd_done_r;
    logic rx_idle, rx_pam4, load_ctle_r, load_dfe_r, idle_status_r;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_r, fix_ctle_r, fix_dfe_r;
    logic [15:0] idle_cfg_r, r;
    logic [1:0]  effort_r;
    paa_cmd_t    cmd;
    paa_eye_t    eye_height;
    int          failures = 0, comparisons = 0, n_ctle = 0, n_dfe = 0;
    int          n_busy = 0;

    // ------------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------------
    always #4 sys_clk = ~sys_clk;

    paa_core i_paa_core (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .reg_rvalid_r(reg_rvalid_r), .cmd(cmd), .cmd_busy_r(cmd_busy_r),
        .cmd_done_r(cmd_done_r), .rx_idle(rx_idle), .rx_pam4(rx_pam4),
        .eye_height(eye_height), .load_ctle_r(load_ctle_r),
        .load_dfe_r(load_dfe_r), .fix_ctle_r(fix_ctle_r),
        .fix_dfe_r(fix_dfe_r), .idle_cfg_r(idle_cfg_r),
        .effort_r(effort_r), .idle_status_r(idle_status_r));

    paa_host i_paa_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .cmd(cmd),
        .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
        .cmd_done_r(cmd_done_r));

    // Load pulses are counted so a missing or doubled pulse shows up.
    always @(posedge sys_clk) begin
        if (load_ctle_r === 1'b1) n_ctle++;
        if (load_dfe_r === 1'b1) n_dfe++;
        if (cmd_busy_r === 1'b1) n_busy++;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // A write is always preceded by the read that selects its target.
    task automatic setp(input logic [15:0] sel, input logic [15:0] v);
        i_paa_host.attr(16'h002C, sel, r);
        i_paa_host.attr(16'h006C, v, r);
        chk("write ack", 16'h002C, r);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] b;
        chk("effort", 16'h0001, {14'h0, effort_r});
        chk("fix ctle", 16'h0000, {8'h00, fix_ctle_r});
        i_paa_host.brd(8'h40, b);
        chk("unmapped", 16'h0000, {8'h00, b});
    endtask

    // The write right after the first loop follows a write, so it is
    // unarmed; the second loop proves it stored nothing.
    task automatic t_params;
        logic [15:0] sels [8] = '{16'h0901, 16'h0900, 16'h0904, 16'h0905,
                                  16'h0D00, 16'h0D08, 16'h0D0A, 16'h200B};
        for (int i = 0; i < 8; i++) begin
            i_paa_host.attr(16'h002C, sels[i], r);
            chk("param reset", 16'h0000, r);
            i_paa_host.attr(16'h006C, 16'hFF00 + 16'(i), r);
            chk("write ack", 16'h002C, r);
        end
        i_paa_host.attr(16'h006C, 16'h1234, r);
        chk("unarmed write", 16'h0000, r);
        i_paa_host.attr(16'h002C, 16'h0902, r);
        i_paa_host.attr(16'h006C, 16'h0077, r);
        chk("hole write", 16'h0000, r);
        for (int i = 0; i < 8; i++) begin
            i_paa_host.attr(16'h002C, sels[i], r);
            chk("param", 16'hFF00 + 16'(i), r);
        end
        setp(16'h2001, 16'h0011);
        setp(16'h2002, 16'hFFEE);
        i_paa_host.attr(16'h002C, 16'h2001, r);
        chk("two part a", 16'h0011, r);
        i_paa_host.attr(16'h002C, 16'h2002, r);
        chk("two part b", 16'hFFEE, r);
    endtask

    task automatic t_load;
        int c0 = n_ctle, d0 = n_dfe, b0 = n_busy;
        i_paa_host.attr(16'h00EC, 16'h0015, r);
        chk("load ack", 16'h00EC, r);
        i_paa_host.attr(16'h00EC, 16'h0012, r);
        chk("load ack", 16'h00EC, r);
        i_paa_host.attr(16'h00EC, 16'h0013, r);
        chk("bad load", 16'h0000, r);
        chk("ctle loads", 16'(c0 + 1), 16'(n_ctle));
        chk("dfe loads", 16'(d0 + 1), 16'(n_dfe));
        chk("busy cycles", 16'(b0 + 3), 16'(n_busy));
    endtask

    task automatic t_fix;
        setp(16'h0108, 16'h00FF);
        chk("fix ctle", 16'h0032, {8'h00, fix_ctle_r});
        i_paa_host.attr(16'h002C, 16'h0108, r);
        chk("fix status", 16'h0032, r);
        setp(16'h0109, 16'h00FF);
        chk("fix dfe", 16'h0019, {8'h00, fix_dfe_r});
    endtask

    task automatic t_eye;
        for (int m = 0; m < 2; m++) begin
            rx_pam4 = m[0];
            for (int i = 0; i < 6; i++) begin
                i_paa_host.attr(16'h002C, 16'h1700 + 16'(i), r);
                chk("eye", m ? eye_height[i] : eye_height[0], r);
            end
        end
    endtask

    task automatic t_idle;
        logic b;
        setp(16'h011C, 16'h0155);
        chk("cfg", 16'h0155, idle_cfg_r);
        eye_height[0] = 16'h0005;
        i_paa_host.attr(16'h4027, 16'h0000, r);
        chk("tune idle", 16'h0030, r);
        eye_height[0] = 16'h0100;
        i_paa_host.attr(16'h4027, 16'h0000, r);
        chk("tune signal", 16'h0020, r);
        setp(16'h011C, 16'hFFF1);
        rx_idle = 1'b1;
        repeat (4100) @(posedge sys_clk);
        #1;
        i_paa_host.attr(16'h4027, 16'h0000, r);
        chk("count idle", 16'h0030, r);
        rx_idle = 1'b0;
        i_paa_host.attr(16'h4027, 16'h0000, r);
        chk("count signal", 16'h0020, r);
        i_paa_host.attr(16'h002C, 16'h011C, r);
        chk("cfg read", 16'hFFF1, r);
        // With a signal present and toggling on, the bit flips each clock.
        setp(16'h011C, 16'h0003);
        b = idle_status_r;
        @(posedge sys_clk) #1;
        chk("toggle", 16'h0001, {15'h0000, b ^ idle_status_r});
        setp(16'h011C, 16'h0000);
        chk("cfg off", 16'h0000, idle_cfg_r);
    endtask

    task automatic t_effort;
        logic [1:0] lv [3] = '{2'b00, 2'b10, 2'b01};
        for (int i = 0; i < 3; i++) begin
            rx_pam4 = (lv[i] == 2'b10);
            setp(16'h0118, {14'h0, lv[i]});
            chk("effort", {14'h0, lv[i]}, {14'h0, effort_r});
            i_paa_host.attr(16'h002C, 16'h0118, r);
            chk("effort read", {14'h0, lv[i]}, r);
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        rx_idle = 1'b0;
        rx_pam4 = 1'b0;
        for (int i = 0; i < 6; i++) eye_height[i] = 16'((i + 1) * 256);
        repeat (16) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        t_reset;
        t_params;
        t_load;
        t_fix;
        t_eye;
        t_idle;
        t_effort;
        finish_test;
    end

    // The run needs about 5000 cycles; this leaves ample margin.
    initial begin
        #320000;
        failures++;
        finish_test;
    end
endmodule
`default_nettype wire
